// *** agcr_time_regs.sv ***
// AGC attack and decay time override registers with effective time outputs
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "agcr_map.svh"

module agcr_time_regs #(
	parameter int TIME_W = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire agcr_pkg::agcr_bus_req_t busReq,
	output logic [7:0] rdata,
	input wire logic [3:0] codecClockRatio,
	input wire logic [TIME_W-1:0] legacyLeftDecayMs,
	input wire logic [TIME_W-1:0] legacyRightAttackMs,
	input wire logic [TIME_W-1:0] legacyRightDecayMs,
	output agcr_pkg::agcr_agc_time_t leftDecayTime,
	output agcr_pkg::agcr_agc_time_t rightAttackTime,
	output agcr_pkg::agcr_agc_time_t rightDecayTime
);

	// All checks run on the one clock and rest while reset is high
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Decode tables
	// ------------------------------------------------------------

	// Baseline decay in ms for a two-bit code
	function automatic logic [TIME_W-1:0] decayBaseMs(input logic [1:0] code);
		logic [TIME_W-1:0] ms;
		ms = TIME_W'(`AGCR_DECAY_MS_0);
		unique case (code)
			2'h0: ms = TIME_W'(`AGCR_DECAY_MS_0);
			2'h1: ms = TIME_W'(`AGCR_DECAY_MS_1);
			2'h2: ms = TIME_W'(`AGCR_DECAY_MS_2);
			2'h3: ms = TIME_W'(`AGCR_DECAY_MS_3);
		endcase
		return ms;
	endfunction : decayBaseMs

	// Baseline attack in ms for a two-bit code
	function automatic logic [TIME_W-1:0] attackBaseMs(input logic [1:0] code);
		logic [TIME_W-1:0] ms;
		ms = TIME_W'(`AGCR_ATTACK_MS_0);
		unique case (code)
			2'h0: ms = TIME_W'(`AGCR_ATTACK_MS_0);
			2'h1: ms = TIME_W'(`AGCR_ATTACK_MS_1);
			2'h2: ms = TIME_W'(`AGCR_ATTACK_MS_2);
			2'h3: ms = TIME_W'(`AGCR_ATTACK_MS_3);
		endcase
		return ms;
	endfunction : attackBaseMs

	// Longest decay allowed at a clock ratio; unknown codes take the tightest cap
	function automatic logic [TIME_W-1:0] decayCapMs(input logic [3:0] ratio);
		logic [TIME_W-1:0] ms;
		ms = TIME_W'(`AGCR_CAP_MS_4P0);
		case (ratio)
			`AGCR_RATIO_1P0: ms = TIME_W'(`AGCR_CAP_MS_4P0);
			`AGCR_RATIO_1P5: ms = TIME_W'(`AGCR_CAP_MS_5P6);
			`AGCR_RATIO_2P0: ms = TIME_W'(`AGCR_CAP_MS_8P0);
			`AGCR_RATIO_2P5: ms = TIME_W'(`AGCR_CAP_MS_9P6);
			`AGCR_RATIO_3P0,
			`AGCR_RATIO_3P5: ms = TIME_W'(`AGCR_CAP_MS_11P2);
			`AGCR_RATIO_4P0,
			`AGCR_RATIO_4P5: ms = TIME_W'(`AGCR_CAP_MS_16P0);
			`AGCR_RATIO_5P0: ms = TIME_W'(`AGCR_CAP_MS_19P2);
			`AGCR_RATIO_5P5,
			`AGCR_RATIO_6P0: ms = TIME_W'(`AGCR_CAP_MS_22P4);
			default: ms = TIME_W'(`AGCR_CAP_MS_4P0);
		endcase
		return ms;
	endfunction : decayCapMs

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------

	agcr_pkg::agcr_field_t leftDecayReg;
	agcr_pkg::agcr_field_t rightAttackReg;
	agcr_pkg::agcr_field_t rightDecayReg;

	// Address decode of the register port
	wire logic hitLeftDecay;
	wire logic hitRightAttack;
	wire logic hitRightDecay;
	assign hitLeftDecay = busReq.addr == `AGCR_OFS_LEFT_DECAY;
	assign hitRightAttack = busReq.addr == `AGCR_OFS_RIGHT_ATTACK;
	assign hitRightDecay = busReq.addr == `AGCR_OFS_RIGHT_DECAY;

	// Write enables per register
	wire logic wrLeftDecay;
	wire logic wrRightAttack;
	wire logic wrRightDecay;
	assign wrLeftDecay = busReq.wr && hitLeftDecay;
	assign wrRightAttack = busReq.wr && hitRightAttack;
	assign wrRightDecay = busReq.wr && hitRightDecay;

	// Read mux; unmapped offsets read zero
	wire logic [7:0] next_rdata;
	assign next_rdata = !busReq.rd ? 8'h00 :
		hitLeftDecay ? leftDecayReg :
		hitRightAttack ? rightAttackReg :
		hitRightDecay ? rightDecayReg : 8'h00;

	// Registers hold the full byte; reserved low bits are kept as written
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			leftDecayReg <= `AGCR_RESET_VALUE;
			rightAttackReg <= `AGCR_RESET_VALUE;
			rightDecayReg <= `AGCR_RESET_VALUE;
		end
		else
		begin
			if (wrLeftDecay)
				leftDecayReg <= busReq.wdata;
			if (wrRightAttack)
				rightAttackReg <= busReq.wdata;
			if (wrRightDecay)
				rightDecayReg <= busReq.wdata;
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			rdata <= 8'h00;
		else
			rdata <= next_rdata;
	end

	// ------------------------------------------------------------
	// Effective times
	// ------------------------------------------------------------

	// Baseline shifted by the multiplier code; 350 ms times 128 fits 16 bits
	wire logic [TIME_W-1:0] leftDecayRaw;
	wire logic [TIME_W-1:0] rightAttackRaw;
	wire logic [TIME_W-1:0] rightDecayRaw;
	assign leftDecayRaw = decayBaseMs(leftDecayReg.base) << leftDecayReg.mult;
	assign rightAttackRaw = attackBaseMs(rightAttackReg.base) << rightAttackReg.mult;
	assign rightDecayRaw = decayBaseMs(rightDecayReg.base) << rightDecayReg.mult;

	// Ratio cap applies to decay only
	wire logic [TIME_W-1:0] decayCap;
	wire logic [TIME_W-1:0] leftDecayNew;
	wire logic [TIME_W-1:0] rightDecayNew;
	assign decayCap = decayCapMs(codecClockRatio);
	assign leftDecayNew = (leftDecayRaw > decayCap) ? decayCap : leftDecayRaw;
	assign rightDecayNew = (rightDecayRaw > decayCap) ? decayCap : rightDecayRaw;

	// Select between legacy timing and this bank
	agcr_pkg::agcr_agc_time_t next_leftDecayTime;
	agcr_pkg::agcr_agc_time_t next_rightAttackTime;
	agcr_pkg::agcr_agc_time_t next_rightDecayTime;
	assign next_leftDecayTime = {leftDecayReg.sel,
		leftDecayReg.sel ? leftDecayNew : legacyLeftDecayMs};
	assign next_rightAttackTime = {rightAttackReg.sel,
		rightAttackReg.sel ? rightAttackRaw : legacyRightAttackMs};
	assign next_rightDecayTime = {rightDecayReg.sel,
		rightDecayReg.sel ? rightDecayNew : legacyRightDecayMs};

	// Times to the AGC channels come from flip-flops
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			leftDecayTime <= '0;
			rightAttackTime <= '0;
			rightDecayTime <= '0;
		end
		else
		begin
			leftDecayTime <= next_leftDecayTime;
			rightAttackTime <= next_rightAttackTime;
			rightDecayTime <= next_rightDecayTime;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------

	// Legacy left decay passes through when select is clear
	chk_left_legacy_path: assert property (
		!leftDecayReg.sel |=> !leftDecayTime.useNew
			&& leftDecayTime.ms == $past(legacyLeftDecayMs))
		else $error("left decay did not follow legacy time");

	// Left baseline figures with unit multiplier
	chk_left_base_ms: assert property (
		leftDecayReg.sel && leftDecayReg.mult == 3'h0 |=>
			leftDecayTime.ms == ($past(leftDecayReg.base) == 2'h0 ? 16'h0032 :
			$past(leftDecayReg.base) == 2'h1 ? 16'h0096 :
			$past(leftDecayReg.base) == 2'h2 ? 16'h00fa : 16'h015e))
		else $error("left baseline decay wrong");

	// Left multiplier doubles per step under the widest cap
	chk_left_mult_step: assert property (
		leftDecayReg.sel && leftDecayReg.base == 2'h0 && codecClockRatio == 4'hc |=>
			leftDecayTime.ms == (16'h0032 << $past(leftDecayReg.mult)))
		else $error("left decay multiplier wrong");

	// Longest decay held to 4 s at ratio 1
	chk_decay_cap_min: assert property (
		leftDecayReg.sel && leftDecayReg.base == 2'h3 && leftDecayReg.mult == 3'h7
			&& codecClockRatio == 4'h2 |=> leftDecayTime.ms == 16'h0fa0)
		else $error("decay not capped at 4 s");

	// Longest decay held to 22.4 s at ratio 6 on the right
	chk_decay_cap_max: assert property (
		rightDecayReg.sel && rightDecayReg.base == 2'h3 && rightDecayReg.mult == 3'h7
			&& codecClockRatio == 4'hc |=> rightDecayTime.ms == 16'h5780)
		else $error("decay not capped at 22.4 s");

	// Legacy right attack passes through when select is clear
	chk_right_attack_legacy: assert property (
		!rightAttackReg.sel |=> !rightAttackTime.useNew
			&& rightAttackTime.ms == $past(legacyRightAttackMs))
		else $error("right attack did not follow legacy time");

	// Right attack baseline figures with unit multiplier
	chk_attack_base_ms: assert property (
		rightAttackReg.sel && rightAttackReg.mult == 3'h0 |=>
			rightAttackTime.ms == ($past(rightAttackReg.base) == 2'h0 ? 16'h0007 :
			$past(rightAttackReg.base) == 2'h1 ? 16'h0008 :
			$past(rightAttackReg.base) == 2'h2 ? 16'h000a : 16'h000b))
		else $error("right baseline attack wrong");

	// Attack multiplier and no cap on attack
	chk_attack_mult_step: assert property (
		rightAttackReg.sel && rightAttackReg.base == 2'h0 |=>
			rightAttackTime.useNew && rightAttackTime.ms == (16'h0007 << $past(rightAttackReg.mult)))
		else $error("right attack multiplier wrong");

	// Legacy right decay passes through when select is clear
	chk_right_decay_legacy: assert property (
		!rightDecayReg.sel |=> !rightDecayTime.useNew
			&& rightDecayTime.ms == $past(legacyRightDecayMs))
		else $error("right decay did not follow legacy time");

	// Right decay decodes like the left one
	chk_right_decay_decode: assert property (
		rightDecayReg.sel && rightDecayReg.base == 2'h2 && codecClockRatio == 4'hc
			&& rightDecayReg.mult <= 3'h6 |=>
			rightDecayTime.ms == (16'h00fa << $past(rightDecayReg.mult)))
		else $error("right decay decode wrong");

	// Registers, read data and the left decay flag are clear right after reset
	chk_reset_clear: assert property (
		$past(rst) |-> leftDecayReg == 8'h00 && rightAttackReg == 8'h00
			&& rightDecayReg == 8'h00 && !leftDecayTime.useNew && rdata == 8'h00)
		else $error("state not clear after reset");

	// Read returns the stored byte one cycle later, then drops
	chk_read_back: assert property (
		busReq.rd && hitRightAttack |=> rdata == $past(rightAttackReg)
			##1 (rdata == 8'h00 || $past(busReq.rd)))
		else $error("read data wrong or held");

	// Write lands in the next cycle
	chk_write_land: assert property (
		wrLeftDecay |=> leftDecayReg == $past(busReq.wdata))
		else $error("write not stored");

	// Read data falls back to zero after a cycle without a read
	chk_rdata_idle: assert property (
		!busReq.rd |=> rdata == 8'h00)
		else $error("read data not zero without a read");

	// Left select bit reaches the left channel flag
	chk_left_select_flag: assert property (
		leftDecayReg.sel |=> leftDecayTime.useNew)
		else $error("left decay flag did not follow select");

	// Right decay select bit reaches the right channel flag
	chk_right_decay_flag: assert property (
		rightDecayReg.sel |=> rightDecayTime.useNew)
		else $error("right decay flag did not follow select");

	// Longest attack is not capped at the tightest ratio
	chk_attack_no_cap: assert property (
		rightAttackReg.sel && rightAttackReg.base == 2'h3 && rightAttackReg.mult == 3'h7
			|=> rightAttackTime.ms == 16'h0580)
		else $error("attack time capped");

	// Longest decay held to 16 s at ratio 4
	chk_decay_cap_mid: assert property (
		leftDecayReg.sel && leftDecayReg.base == 2'h3 && leftDecayReg.mult == 3'h7
			&& codecClockRatio == 4'h8 |=> leftDecayTime.ms == 16'h3e80)
		else $error("decay not capped at 16 s");

	// Unknown ratio codes take the 4 s cap
	chk_bad_ratio_cap: assert property (
		leftDecayReg.sel && leftDecayReg.base == 2'h3 && leftDecayReg.mult == 3'h7
			&& codecClockRatio == 4'h0 |=> leftDecayTime.ms == 16'h0fa0)
		else $error("unknown ratio not capped at 4 s");

endmodule : agcr_time_regs

// *** agcr_map.svh ***
// Offsets, field positions, reset values and timing figures of the AGC time registers
`ifndef AGCR_MAP_SVH
`define AGCR_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define AGCR_OFS_LEFT_DECAY 8'h68
`define AGCR_OFS_RIGHT_ATTACK 8'h69
`define AGCR_OFS_RIGHT_DECAY 8'h6a

// ------------------------------------------------------------
// Field positions and reset value
// ------------------------------------------------------------
`define AGCR_SEL_POS 7
`define AGCR_BASE_MSB 6
`define AGCR_BASE_LSB 5
`define AGCR_MULT_MSB 4
`define AGCR_MULT_LSB 2
`define AGCR_RSVD_MSB 1
`define AGCR_RSVD_LSB 0
`define AGCR_RESET_VALUE 8'h00

// ------------------------------------------------------------
// Baseline times in milliseconds
// ------------------------------------------------------------
`define AGCR_DECAY_MS_0 16'h0032
`define AGCR_DECAY_MS_1 16'h0096
`define AGCR_DECAY_MS_2 16'h00fa
`define AGCR_DECAY_MS_3 16'h015e
`define AGCR_ATTACK_MS_0 16'h0007
`define AGCR_ATTACK_MS_1 16'h0008
`define AGCR_ATTACK_MS_2 16'h000a
`define AGCR_ATTACK_MS_3 16'h000b

// ------------------------------------------------------------
// Clock ratio codes (ratio times two) and decay caps in ms
// ------------------------------------------------------------
`define AGCR_RATIO_1P0 4'h2
`define AGCR_RATIO_1P5 4'h3
`define AGCR_RATIO_2P0 4'h4
`define AGCR_RATIO_2P5 4'h5
`define AGCR_RATIO_3P0 4'h6
`define AGCR_RATIO_3P5 4'h7
`define AGCR_RATIO_4P0 4'h8
`define AGCR_RATIO_4P5 4'h9
`define AGCR_RATIO_5P0 4'ha
`define AGCR_RATIO_5P5 4'hb
`define AGCR_RATIO_6P0 4'hc
`define AGCR_CAP_MS_4P0 16'h0fa0
`define AGCR_CAP_MS_5P6 16'h15e0
`define AGCR_CAP_MS_8P0 16'h1f40
`define AGCR_CAP_MS_9P6 16'h2580
`define AGCR_CAP_MS_11P2 16'h2bc0
`define AGCR_CAP_MS_16P0 16'h3e80
`define AGCR_CAP_MS_19P2 16'h4b00
`define AGCR_CAP_MS_22P4 16'h5780

`endif

// *** agcr_pkg.sv ***
// Types shared by the AGC time register bank
package agcr_pkg;

	// One AGC timing register, most significant field first
	typedef struct packed {
		logic sel;
		logic [1:0] base;
		logic [2:0] mult;
		logic [1:0] rsvd;
	} agcr_field_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} agcr_bus_req_t;

	// Time handed to one AGC channel
	typedef struct packed {
		logic useNew;
		logic [15:0] ms;
	} agcr_agc_time_t;

endpackage : agcr_pkg

// *** agcr_time_regs_test.sv ***
// Self-checking bench for the AGC time register bank
`timescale 1ns/1ps
`include "agcr_map.svh"

module agcr_time_regs_test;
	// ------------------------------------------------------------
	// Row layout: offset, written value, ratio code, expected ms
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic [3:0] ratio;
		logic [15:0] ms;
	} agcr_row_t;

	logic clock = 1'b0;
	logic rst = 1'b1;
	agcr_pkg::agcr_bus_req_t busReq = '0;
	logic [7:0] rdata;
	logic [3:0] codecClockRatio = 4'h2;
	logic [15:0] legacyLeftDecayMs = 16'h1234;
	logic [15:0] legacyRightAttackMs = 16'h0456;
	logic [15:0] legacyRightDecayMs = 16'h0789;
	agcr_pkg::agcr_agc_time_t leftDecayTime;
	agcr_pkg::agcr_agc_time_t rightAttackTime;
	agcr_pkg::agcr_agc_time_t rightDecayTime;
	logic [16:0] seen;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;

	// Baselines, every multiplier code, every ratio cap
	agcr_row_t rows [30] = '{
		{8'h68, 8'h80, 4'h2, 16'h0032}, {8'h68, 8'ha0, 4'h2, 16'h0096},
		{8'h68, 8'hc0, 4'h2, 16'h00fa}, {8'h68, 8'he0, 4'h2, 16'h015e},
		{8'h68, 8'h8c, 4'h2, 16'h0190}, {8'h68, 8'h9c, 4'h2, 16'h0fa0},
		{8'h68, 8'h9c, 4'h4, 16'h1900}, {8'h68, 8'hfc, 4'h0, 16'h0fa0},
		{8'h68, 8'hfc, 4'h3, 16'h15e0}, {8'h68, 8'hfc, 4'h4, 16'h1f40},
		{8'h68, 8'hfc, 4'h5, 16'h2580}, {8'h68, 8'hfc, 4'h6, 16'h2bc0},
		{8'h68, 8'hfc, 4'h7, 16'h2bc0}, {8'h68, 8'hfc, 4'h8, 16'h3e80},
		{8'h68, 8'hfc, 4'h9, 16'h3e80}, {8'h68, 8'hfc, 4'ha, 16'h4b00},
		{8'h68, 8'hfc, 4'hb, 16'h5780}, {8'h68, 8'hfc, 4'hc, 16'h5780},
		{8'h68, 8'hd8, 4'hc, 16'h3e80}, {8'h69, 8'h80, 4'h2, 16'h0007},
		{8'h69, 8'ha0, 4'h2, 16'h0008}, {8'h69, 8'hc0, 4'h2, 16'h000a},
		{8'h69, 8'he4, 4'h2, 16'h0016}, {8'h69, 8'h88, 4'h2, 16'h001c},
		{8'h69, 8'h90, 4'h2, 16'h0070}, {8'h69, 8'h98, 4'h2, 16'h01c0},
		{8'h69, 8'hfc, 4'h2, 16'h0580}, {8'h6a, 8'hb4, 4'h3, 16'h12c0},
		{8'h6a, 8'hb4, 4'h2, 16'h0fa0}, {8'h6a, 8'hfc, 4'h8, 16'h3e80}
	};

	// ------------------------------------------------------------
	// Clock, design and cycle ceiling
	// ------------------------------------------------------------
	always #20 clock = ~clock;

	agcr_time_regs DUT (
		.clock(clock),
		.rst(rst),
		.busReq(busReq),
		.rdata(rdata),
		.codecClockRatio(codecClockRatio),
		.legacyLeftDecayMs(legacyLeftDecayMs),
		.legacyRightAttackMs(legacyRightAttackMs),
		.legacyRightDecayMs(legacyRightDecayMs),
		.leftDecayTime(leftDecayTime),
		.rightAttackTime(rightAttackTime),
		.rightDecayTime(rightDecayTime)
	);

	// Cuts a hang short
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [16:0] got, input logic [16:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		busReq.wr <= 1'b0;
	endtask : wrReg

	task automatic rdReg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		busReq.rd <= 1'b0;
		#1;
		check("rdata", {9'h000, rdata}, {9'h000, exp});
	endtask : rdReg

	task automatic chkLegacy();
		check("left", leftDecayTime, {1'b0, legacyLeftDecayMs});
		check("rattack", rightAttackTime, {1'b0, legacyRightAttackMs});
		check("rdecay", rightDecayTime, {1'b0, legacyRightDecayMs});
	endtask : chkLegacy

	task automatic chkCleared();
		rdReg(`AGCR_OFS_LEFT_DECAY, `AGCR_RESET_VALUE);
		rdReg(`AGCR_OFS_RIGHT_ATTACK, `AGCR_RESET_VALUE);
		rdReg(`AGCR_OFS_RIGHT_DECAY, `AGCR_RESET_VALUE);
		chkLegacy();
	endtask : chkCleared

	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		tick(2);
		chkCleared();
		// Table rows, reserved bits always written as zero
		foreach (rows[i])
		begin
			@(posedge clock);
			codecClockRatio <= rows[i].ratio;
			wrReg(rows[i].addr, rows[i].data);
			tick(2);
			seen = (rows[i].addr == `AGCR_OFS_LEFT_DECAY) ? leftDecayTime :
				((rows[i].addr == `AGCR_OFS_RIGHT_ATTACK) ? rightAttackTime : rightDecayTime);
			check("time", seen, {1'b1, rows[i].ms});
			rdReg(rows[i].addr, rows[i].data);
		end
		// Select cleared with fields still set, then legacy input moves
		wrReg(`AGCR_OFS_LEFT_DECAY, 8'h7c);
		wrReg(`AGCR_OFS_RIGHT_ATTACK, 8'h7c);
		wrReg(`AGCR_OFS_RIGHT_DECAY, 8'h78);
		@(posedge clock);
		legacyLeftDecayMs <= 16'h0abc;
		tick(2);
		chkLegacy();
		// Unmapped offsets ignored on write, read as zero
		wrReg(8'h67, 8'hfc);
		wrReg(8'h6b, 8'hfc);
		rdReg(8'h67, 8'h00);
		rdReg(`AGCR_OFS_LEFT_DECAY, 8'h7c);
		// Back-to-back reads, data stands one cycle only
		@(posedge clock);
		busReq <= '{addr: `AGCR_OFS_RIGHT_ATTACK, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		busReq.addr <= `AGCR_OFS_RIGHT_DECAY;
		#1;
		check("rdata", {9'h000, rdata}, {9'h000, 8'h7c});
		@(posedge clock);
		busReq.rd <= 1'b0;
		#1;
		check("rdata", {9'h000, rdata}, {9'h000, 8'h78});
		tick(1);
		check("rdata", {9'h000, rdata}, 17'h00000);
		// Reset in mid-run clears every field
		wrReg(`AGCR_OFS_LEFT_DECAY, 8'h80);
		@(posedge clock);
		rst <= 1'b1;
		tick(1);
		check("left", leftDecayTime, 17'h00000);
		@(posedge clock);
		rst <= 1'b0;
		tick(2);
		chkCleared();
		wrap_up();
	end
endmodule : agcr_time_regs_test
